// ==== logic/pcf_pkg.sv ====
// Package: register map, field layouts and code tables of the control field codec
package pcf_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXCFG = 8'h04;
   localparam logic [7:0] OFS_TXSTAT = 8'h08;
   localparam logic [7:0] OFS_RXIN = 8'h0c;
   localparam logic [7:0] OFS_RXSTAT = 8'h10;
   localparam logic [7:0] OFS_GCFG = 8'h14;
   localparam logic [7:0] OFS_GTX = 8'h18;
   localparam logic [7:0] OFS_GRX = 8'h1c;
   localparam logic [7:0] OFS_GSTAT = 8'h20;

   // Control MCS codes, stream codes, reserved selector and count reset value
   localparam logic [3:0] MCS_LOWEST = 4'h0;
   localparam logic [3:0] MCS_SHARED_MAX = 4'h3;
   localparam logic [3:0] MCS_RSVD = 4'h4;
   localparam logic [3:0] MCS_TOP = 4'ha;
   localparam logic [1:0] STREAM_ONE = 2'h0;
   localparam logic [1:0] STREAM_RSVD = 2'h3;
   localparam logic [1:0] ULIDX_RSVD = 2'h0;
   localparam logic [5:0] BW_COUNT_RST = 6'h00;

   // Power command steps in dB, indexed by the 2-bit command
   localparam logic signed [3:0] TPC_ACC_DB [4] = '{4'shf, 4'sh0, 4'sh1, 4'sh3};
   localparam logic signed [3:0] TPC_ABS_DB [4] = '{4'shc, 4'shf, 4'sh1, 4'sh4};

   typedef enum logic [1:0] {MIMO_STBC = 2'h0, MIMO_SM = 2'h1, MIMO_SVD = 2'h2, MIMO_SDMA = 2'h3} pcf_mimo_e;
   typedef enum logic [2:0] {MOD_NONE = 3'h0, MOD_BPSK = 3'h1, MOD_QPSK = 3'h2, MOD_QAM16 = 3'h3,
                             MOD_QAM64 = 3'h4, MOD_QAM256 = 3'h5} pcf_mod_e;
   typedef enum logic [2:0] {RATE_NONE = 3'h0, RATE_1_2 = 3'h1, RATE_2_3 = 3'h2, RATE_3_4 = 3'h3,
                             RATE_5_6 = 3'h4, RATE_7_8 = 3'h5} pcf_rate_e;

   typedef struct packed {
      logic [28:0] rsvd;
      logic sharedChan;
      logic harqRetx;
      logic contMode;
   } pcf_ctrl_s;

   typedef struct packed {
      logic [5:0] rsvd;
      logic [3:0] mimoCap;
      logic [4:0] bwLast;
      logic [4:0] bwFirst;
      logic [1:0] streamInd;
      logic [1:0] mimoType;
      logic [3:0] reqWant;
      logic [3:0] mcsNeed;
   } pcf_txcfg_s;

   typedef struct packed {
      logic [18:0] rsvd;
      logic mimoRejected;
      logic [1:0] stream;
      logic [1:0] mimo;
      logic [3:0] req;
      logic [3:0] ind;
   } pcf_txstat_s;

   typedef struct packed {
      logic [8:0] rsvd;
      logic crcOk;
      logic [4:0] bwLast;
      logic [4:0] bwFirst;
      logic [1:0] stream;
      logic [1:0] mimo;
      logic [3:0] req;
      logic [3:0] ind;
   } pcf_rxin_s;

   typedef struct packed {
      logic [3:0] rsvd;
      pcf_rate_e peerRate;
      pcf_mod_e peerMod;
      logic bwInvalid;
      logic fieldErr;
      logic peerReqKnown;
      logic siso;
      logic [5:0] count;
      logic [1:0] stream;
      logic [1:0] mimo;
      logic [3:0] req;
      logic [3:0] ind;
   } pcf_rxstat_s;

   typedef struct packed {
      logic [1:0] ulIdx;
      logic [2:0] cshift;
      logic [1:0] tpc;
      logic ndt;
      logic [4:0] mcsRv;
      logic hop;
      logic fmt;
   } pcf_grant_s;

   typedef struct packed {
      logic [14:0] rsvd;
      logic slotCfg0;
      logic newBlock;
      pcf_grant_s grant;
   } pcf_gcfg_s;

   typedef struct packed {
      logic [9:0] rsvd;
      logic slot2;
      logic slot1;
      logic hopOn;
      logic signed [3:0] tpcDb;
      pcf_grant_s grant;
   } pcf_gstat_s;

   localparam logic [3:0] MIMO_CAP_RST = 4'h1;

   function automatic logic pcfMcsValid(input logic [3:0] id);
      return (id <= MCS_TOP) && (id != MCS_RSVD);
   endfunction : pcfMcsValid

   function automatic logic [3:0] pcfMin(input logic [3:0] a, input logic [3:0] b);
      return (a < b) ? a : b;
   endfunction : pcfMin

endpackage : pcf_pkg

// ==== logic/pcf_mcs_lookup.sv ====
// Decodes a control MCS code into modulation and code rate
`timescale 1ns/1ps
`default_nettype none
module pcf_mcs_lookup
   import pcf_pkg::*;
(
   input wire logic [3:0] mcsId,
   output logic valid,
   output pcf_mod_e modulation,
   output pcf_rate_e rate
);

   always_comb
   begin
      valid = pcfMcsValid(mcsId);
      modulation = MOD_NONE;
      rate = RATE_NONE;
      case (mcsId)
         4'h0:
         begin
            modulation = MOD_BPSK;
            rate = RATE_1_2;
         end
         4'h1:
         begin
            modulation = MOD_BPSK;
            rate = RATE_2_3;
         end
         4'h2:
         begin
            modulation = MOD_QPSK;
            rate = RATE_1_2;
         end
         4'h3:
         begin
            modulation = MOD_QPSK;
            rate = RATE_3_4;
         end
         4'h5:
         begin
            modulation = MOD_QAM16;
            rate = RATE_1_2;
         end
         4'h6:
         begin
            modulation = MOD_QAM16;
            rate = RATE_3_4;
         end
         4'h7:
         begin
            modulation = MOD_QAM64;
            rate = RATE_2_3;
         end
         4'h8:
         begin
            modulation = MOD_QAM64;
            rate = RATE_5_6;
         end
         4'h9:
         begin
            modulation = MOD_QAM256;
            rate = RATE_3_4;
         end
         4'ha:
         begin
            modulation = MOD_QAM256;
            rate = RATE_7_8;
         end
         default:
         begin
            modulation = MOD_NONE;
            rate = RATE_NONE;
         end
      endcase
   end

endmodule : pcf_mcs_lookup
`default_nettype wire

// ==== logic/pcf_grant_decode.sv ====
// Interprets a received uplink grant: power step, hopping and slot selection
`timescale 1ns/1ps
`default_nettype none
module pcf_grant_decode
   import pcf_pkg::*;
(
   input wire pcf_grant_s grant,
   input wire logic slotCfg0,
   output logic signed [3:0] tpcDb,
   output logic hopOn,
   output logic slotValid,
   output logic slot1,
   output logic slot2
);

   always_comb
   begin
      // Absolute steps exist only in the uplink grant format
      tpcDb = grant.fmt ? TPC_ACC_DB[grant.tpc] : TPC_ABS_DB[grant.tpc];
      hopOn = ~grant.hop;
      // The selector means nothing outside slot configuration 0
      slotValid = slotCfg0 && (grant.ulIdx != ULIDX_RSVD);
      slot1 = slotValid & grant.ulIdx[1];
      slot2 = slotValid & grant.ulIdx[0];
   end

endmodule : pcf_grant_decode
`default_nettype wire

// ==== logic/pcf_codec.sv ====
// Control field codec: AHB-Lite register slave, field selection and field decoding
//
// Operation
// - Indicator IDs 0-10 coded, 4 and 11-15 reserved
// - Shared channel indicator BPSK 1/2 to QPSK 3/4
// - Individual channel indicator up to 256QAM 7/8
// - Continuous mode retransmission repeats first content
// - MCS request uses same table as indicator
// - Individual indicator never above peer request
// - Shared channel uses lowest sufficient MCS
// - Request from failed CRC block is ignored
// - HARQ retransmission keeps initial MCS request; not held on the shared channel outside continuous mode
// - MIMO type codes STBC, SM, SVD, SDMA
// - MIMO type only from negotiated capabilities
// - SDMA with one stream means single-stream adaptive array
// - Stream codes one, two, four, reserved
// - Bandwidth field holds first and last subchannel
// - Subchannel count is last minus first plus one
// - Format flag 0 uplink grant, 1 compact downlink
// - Hopping flag 0 hops, 1 does not
// - Five-bit field joins modulation, size, redundancy
// - New-data toggle inverts per new block only
// - Power command accumulated or absolute dB steps
// - Three-bit cyclic shift picks demodulation pilot
// - Uplink slot selector only for slot configuration 0
// - Selector 10 first, 01 second, 11 both slots
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pcf_codec
   import pcf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output pcf_txstat_s txFields,
   output pcf_grant_s txGrant,
   output logic peerSiso
);

   pcf_ctrl_s ctrl_q;
   pcf_txcfg_s txCfg_q;
   pcf_txstat_s txStat_q;
   pcf_rxstat_s rxStat_q;
   pcf_gcfg_s gCfg_q;
   pcf_grant_s gTx_q;
   pcf_gstat_s gStat_q;
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic addrPhase;
   logic wrStb;
   pcf_rxin_s rxIn;
   pcf_gcfg_s gCfgIn;
   pcf_grant_s gRxIn;
   logic indHold;
   logic reqHold;
   logic [3:0] capMcs;
   logic [3:0] txInd_d;
   logic rxIndValid;
   pcf_mod_e rxMod;
   pcf_rate_e rxRate;
   logic signed [3:0] gTpcDb;
   logic gHopOn;
   logic gSlotValid;
   logic gSlot1;
   logic gSlot2;

   // Zero wait states; a low clock enable stalls the bus so no transfer is lost
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdData_q;
   assign txFields = txStat_q;
   assign txGrant = gTx_q;
   assign peerSiso = rxStat_q.siso;

   assign addrPhase = ce && hsel && hready && htrans[1];
   assign wrStb = ce && wrPend_q;
   assign rxIn = pcf_rxin_s'(hwdata);
   assign gCfgIn = pcf_gcfg_s'(hwdata);
   assign gRxIn = pcf_grant_s'(hwdata[14:0]);

   // Address phase capture; writes land in the following data phase
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end
      else if (ce && hready)
      begin
         wrPend_q <= hsel && htrans[1] && hwrite;
         wrAddr_q <= haddr[7:0];
      end
   end

   always_comb
   begin
      rdData_d = 32'h00000000;
      case (haddr[7:0])
         OFS_CTRL: rdData_d = ctrl_q;
         OFS_TXCFG: rdData_d = txCfg_q;
         OFS_TXSTAT: rdData_d = txStat_q;
         OFS_RXSTAT: rdData_d = rxStat_q;
         OFS_GCFG: rdData_d = gCfg_q;
         OFS_GTX: rdData_d = {17'h00000, gTx_q};
         OFS_GSTAT: rdData_d = gStat_q;
         default: rdData_d = 32'h00000000;
      endcase
   end

   // Read data is sampled at the address phase so it comes straight from a flop
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdData_q <= 32'h00000000;
      else if (addrPhase && !hwrite)
         rdData_q <= rdData_d;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= '0;
         txCfg_q <= '0;
         txCfg_q.mimoCap <= MIMO_CAP_RST;
      end
      else if (wrStb)
      begin
         if (wrAddr_q == OFS_CTRL)
         begin
            ctrl_q <= '0;
            ctrl_q.contMode <= hwdata[0];
            ctrl_q.harqRetx <= hwdata[1];
            ctrl_q.sharedChan <= hwdata[2];
         end
         if (wrAddr_q == OFS_TXCFG)
         begin
            txCfg_q <= pcf_txcfg_s'(hwdata);
            txCfg_q.rsvd <= '0;
         end
      end
   end

   // Transmit field selection
   assign indHold = ctrl_q.contMode && ctrl_q.harqRetx;
   assign reqHold = ctrl_q.harqRetx && (ctrl_q.contMode || !ctrl_q.sharedChan);
   // An unknown peer request allows only the most robust code
   assign capMcs = rxStat_q.peerReqKnown ? rxStat_q.req : MCS_LOWEST;

   always_comb
   begin
      if (ctrl_q.sharedChan)
         txInd_d = pcfMin(txCfg_q.mcsNeed, MCS_SHARED_MAX);
      else
      begin
         txInd_d = pcfMin(pcfMin(txCfg_q.mcsNeed, capMcs), MCS_TOP);
         if (txInd_d == MCS_RSVD)
            txInd_d = MCS_SHARED_MAX;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         txStat_q <= '0;
      else if (ce)
      begin
         if (!indHold)
         begin
            txStat_q.ind <= txInd_d;
            if (txCfg_q.mimoCap[txCfg_q.mimoType])
            begin
               txStat_q.mimo <= txCfg_q.mimoType;
               txStat_q.mimoRejected <= 1'b0;
            end
            else
               txStat_q.mimoRejected <= 1'b1;
            if (txCfg_q.streamInd != STREAM_RSVD)
               txStat_q.stream <= txCfg_q.streamInd;
         end
         if (!reqHold && pcfMcsValid(txCfg_q.reqWant))
            txStat_q.req <= txCfg_q.reqWant;
      end
   end

   pcf_mcs_lookup u_rxMcs (
      .mcsId(rxStat_q.ind),
      .valid(rxIndValid),
      .modulation(rxMod),
      .rate(rxRate)
   );

   // Receive side: software posts the fields of a decoded control block
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rxStat_q <= '0;
         rxStat_q.count <= BW_COUNT_RST;
      end
      else if (ce)
      begin
         rxStat_q.peerMod <= rxIndValid ? rxMod : MOD_NONE;
         rxStat_q.peerRate <= rxRate;
         rxStat_q.siso <= (rxStat_q.mimo == MIMO_SDMA) && (rxStat_q.stream == STREAM_ONE);
         if (wrStb && wrAddr_q == OFS_RXIN)
         begin
            if (!rxIn.crcOk)
               rxStat_q.peerReqKnown <= 1'b0;
            else
            begin
               if (pcfMcsValid(rxIn.ind))
                  rxStat_q.ind <= rxIn.ind;
               if (pcfMcsValid(rxIn.req))
               begin
                  rxStat_q.req <= rxIn.req;
                  rxStat_q.peerReqKnown <= 1'b1;
               end
               rxStat_q.mimo <= rxIn.mimo;
               if (rxIn.stream != STREAM_RSVD)
                  rxStat_q.stream <= rxIn.stream;
               rxStat_q.fieldErr <= !pcfMcsValid(rxIn.ind) || !pcfMcsValid(rxIn.req)
                                    || (rxIn.stream == STREAM_RSVD);
               if (rxIn.bwLast >= rxIn.bwFirst)
               begin
                  rxStat_q.count <= 6'({1'b0, rxIn.bwLast} - {1'b0, rxIn.bwFirst} + 6'h01);
                  rxStat_q.bwInvalid <= 1'b0;
               end
               else
                  rxStat_q.bwInvalid <= 1'b1;
            end
         end
      end
   end

   // Uplink grant building; the toggle flips only when a new block is announced
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         gCfg_q <= '0;
         gTx_q <= '0;
      end
      else if (wrStb && wrAddr_q == OFS_GCFG)
      begin
         gCfg_q <= '0;
         gCfg_q.slotCfg0 <= gCfgIn.slotCfg0;
         gCfg_q.grant <= gCfgIn.grant;
         gTx_q.fmt <= gCfgIn.grant.fmt;
         gTx_q.hop <= gCfgIn.grant.hop;
         gTx_q.mcsRv <= gCfgIn.grant.mcsRv;
         gTx_q.tpc <= gCfgIn.grant.tpc;
         gTx_q.cshift <= gCfgIn.grant.cshift;
         // Selector is zeroed outside configuration 0 where it does not apply
         gTx_q.ulIdx <= gCfgIn.slotCfg0 ? gCfgIn.grant.ulIdx : ULIDX_RSVD;
         if (gCfgIn.newBlock)
            gTx_q.ndt <= ~gTx_q.ndt;
      end
   end

   pcf_grant_decode u_grantRx (
      .grant(gStat_q.grant),
      .slotCfg0(gCfg_q.slotCfg0),
      .tpcDb(gTpcDb),
      .hopOn(gHopOn),
      .slotValid(gSlotValid),
      .slot1(gSlot1),
      .slot2(gSlot2)
   );

   // Received grant: raw fields on write, interpretation follows one cycle later
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         gStat_q <= '0;
      else if (ce)
      begin
         if (wrStb && wrAddr_q == OFS_GRX)
            gStat_q.grant <= gRxIn;
         gStat_q.tpcDb <= gTpcDb;
         gStat_q.hopOn <= gHopOn;
         if (gSlotValid)
         begin
            gStat_q.slot1 <= gSlot1;
            gStat_q.slot2 <= gSlot2;
         end
      end
   end

   // Checks
   sequence s_newBlock;
      wrStb && wrAddr_q == OFS_GCFG && gCfgIn.newBlock;
   endsequence

   sequence s_sameBlock;
      wrStb && wrAddr_q == OFS_GCFG && !gCfgIn.newBlock;
   endsequence

   sequence s_badCrc;
      wrStb && wrAddr_q == OFS_RXIN && !rxIn.crcOk;
   endsequence

   a_ind_not_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      pcfMcsValid(txStat_q.ind))
      else $error("transmitted indicator is a reserved code");

   a_shared_range: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !indHold && ctrl_q.sharedChan) |=> (txStat_q.ind <= MCS_SHARED_MAX))
      else $error("shared channel indicator above QPSK 3/4");

   a_shared_lowest: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !indHold && ctrl_q.sharedChan && txCfg_q.mcsNeed <= MCS_SHARED_MAX)
      |=> (txStat_q.ind == $past(txCfg_q.mcsNeed)))
      else $error("shared channel did not pick the lowest sufficient code");

   a_indiv_capped: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !indHold && !ctrl_q.sharedChan) |=> (txStat_q.ind <= $past(capMcs)))
      else $error("individual indicator exceeds peer request");

   a_retx_frozen: assert property (@(posedge ref_clk) disable iff (rst)
      (indHold && !wrStb) [*2] |=> ($stable(txStat_q.ind) && $stable(txStat_q.mimo) && $stable(txStat_q.stream)))
      else $error("retransmitted content changed in continuous mode");

   a_req_frozen: assert property (@(posedge ref_clk) disable iff (rst)
      reqHold |=> $stable(txStat_q.req))
      else $error("request changed during HARQ retransmission");

   a_crc_drop: assert property (@(posedge ref_clk) disable iff (rst)
      s_badCrc |=> (!rxStat_q.peerReqKnown && $stable(rxStat_q.req)))
      else $error("request from failed block was used");

   a_mimo_cap: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !indHold && !txCfg_q.mimoCap[txCfg_q.mimoType]) |=> ($stable(txStat_q.mimo) && txStat_q.mimoRejected))
      else $error("unnegotiated MIMO type transmitted");

   a_siso_flag: assert property (@(posedge ref_clk) disable iff (rst)
      ce |=> (rxStat_q.siso == ($past(rxStat_q.mimo) == MIMO_SDMA && $past(rxStat_q.stream) == STREAM_ONE)))
      else $error("single-stream adaptive array flag wrong");

   a_ndt_toggle: assert property (@(posedge ref_clk) disable iff (rst)
      s_newBlock |=> (gTx_q.ndt != $past(gTx_q.ndt)))
      else $error("new-data toggle did not invert on new block");

   a_ndt_keep: assert property (@(posedge ref_clk) disable iff (rst)
      s_sameBlock |=> $stable(gTx_q.ndt))
      else $error("new-data toggle changed on retransmission");

   a_bw_count: assert property (@(posedge ref_clk) disable iff (rst)
      (wrStb && wrAddr_q == OFS_RXIN && rxIn.crcOk && rxIn.bwLast >= rxIn.bwFirst)
      |=> (rxStat_q.count == $past(6'({1'b0, rxIn.bwLast} - {1'b0, rxIn.bwFirst}) + 6'h01)) && !rxStat_q.bwInvalid)
      else $error("subchannel count wrong");

   a_bw_invalid: assert property (@(posedge ref_clk) disable iff (rst)
      (wrStb && wrAddr_q == OFS_RXIN && rxIn.crcOk && rxIn.bwLast < rxIn.bwFirst)
      |=> (rxStat_q.bwInvalid && $stable(rxStat_q.count)))
      else $error("inverted bandwidth range not flagged");

   a_slot_keep: assert property (@(posedge ref_clk) disable iff (rst)
      (ce && !gSlotValid) |=> ($stable(gStat_q.slot1) && $stable(gStat_q.slot2)))
      else $error("reserved slot selector changed the schedule");

endmodule : pcf_codec
`default_nettype wire

// ==== tb/pcf_peer_model.sv ====
// Peer station model: packs received control words and watches the transmit indicator
`timescale 1ns/1ps
`default_nettype none
module pcf_peer_model
   import pcf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic individual,
   input wire pcf_txstat_s txFields,
   output logic [7:0] violations
);
   logic [3:0] lastReq = 4'h0;
   logic known = 1'b0;
   logic [1:0] indivHist;

   // Received control block as the peer sends it
   function automatic logic [31:0] rxWord(input logic crc, input logic [4:0] last, input logic [4:0] first,
                                          input logic [1:0] st, input logic [1:0] mimoSel, input logic [3:0] rq,
                                          input logic [3:0] id);
      return {9'h000, crc, last, first, st, mimoSel, rq, id};
   endfunction : rxWord

   // Uplink grant as the peer builds it
   function automatic logic [14:0] grantWord(input logic [1:0] ul, input logic [2:0] cs, input logic [1:0] tpc,
                                             input logic ndt, input logic [4:0] mcs, input logic hop, input logic fmt);
      return {ul, cs, tpc, ndt, mcs, hop, fmt};
   endfunction : grantWord

   // A block with a failed check leaves the peer's request unknown
   task automatic sent(input logic [3:0] rq, input logic crc);
      if (!crc)
         known = 1'b0;
      else if (rq <= 4'ha && rq != 4'h4)
      begin
         known = 1'b1;
         lastReq = rq;
      end
   endtask : sent

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         indivHist <= 2'h0;
         violations <= 8'h00;
      end
      else
      begin
         indivHist <= {indivHist[0], individual};
         // Mode changes need two cycles to reach the indicator, so judge only a settled mode
         if ((&indivHist) && individual && (known ? (txFields.ind > lastReq) : (txFields.ind != 4'h0)))
            violations <= violations + 8'h01;
      end
   end
endmodule : pcf_peer_model
`default_nettype wire

// ==== tb/pcf_codec_bench.sv ====
// Self-checking bench of the control field codec over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module pcf_codec_bench
   import pcf_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] rd;
   pcf_txstat_s txFields;
   pcf_grant_s txGrant;
   logic peerSiso;
   logic indiv = 1'b0;
   logic [7:0] violations;
   pcf_rxstat_s rx = '0;
   logic s1 = 1'b0;
   logic s2 = 1'b0;
   logic [14:0] gr;
   logic [3:0] e;
   int n_mismatch = 0;
   int n_checks = 0;
   localparam logic [5:0] MOD_TAB [11] = '{6'h09, 6'h0a, 6'h11, 6'h13, 6'h00, 6'h19, 6'h1b, 6'h22, 6'h24, 6'h2b, 6'h2d};
   localparam logic [3:0] ACC_DB [4] = '{4'hf, 4'h0, 4'h1, 4'h3};
   localparam logic [3:0] ABS_DB [4] = '{4'hc, 4'hf, 4'h1, 4'h4};

   always #5 ref_clk = ~ref_clk;

   pcf_codec u_pcf_codec (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .txFields(txFields), .txGrant(txGrant), .peerSiso(peerSiso));

   pcf_peer_model u_pcf_peer_model (.ref_clk(ref_clk), .rst(rst), .individual(indiv), .txFields(txFields),
      .violations(violations));

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chkWord

   // Select stays up between transfers so back-to-back calls never assign it twice in one step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   // Two idle cycles let derived fields settle before anything is looked at
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (2) @(posedge ref_clk);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chkWord(rd, exp);
   endtask : rdChk

   function automatic logic okId(input logic [3:0] x);
      return x <= 4'ha && x != 4'h4;
   endfunction : okId

   function automatic logic [31:0] cfg(input logic [3:0] cap, input logic [1:0] mimoSel, input logic [3:0] rq,
                                       input logic [3:0] need);
      return {6'h0, cap, 10'h000, 2'h0, mimoSel, rq, need};
   endfunction : cfg

   task automatic rxSend(input logic crc, input logic [4:0] last, input logic [4:0] first, input logic [1:0] st,
                         input logic [1:0] mimoSel, input logic [3:0] rq, input logic [3:0] id);
      // The peer knows its own request from the moment it sends it
      u_pcf_peer_model.sent(rq, crc);
      wr(OFS_RXIN, u_pcf_peer_model.rxWord(crc, last, first, st, mimoSel, rq, id));
      if (!crc)
         rx.peerReqKnown = 1'b0;
      else
      begin
         rx.fieldErr = !okId(id) || !okId(rq) || st == 2'h3;
         if (okId(id))
            rx.ind = id;
         if (okId(rq))
            {rx.peerReqKnown, rx.req} = {1'b1, rq};
         rx.mimo = mimoSel;
         if (st != 2'h3)
            rx.stream = st;
         rx.bwInvalid = last < first;
         if (last >= first)
            rx.count = 6'(last) - 6'(first) + 6'h01;
      end
      rx.siso = rx.mimo == 2'h3 && rx.stream == 2'h0;
      rx.peerMod = pcf_mod_e'(MOD_TAB[rx.ind][5:3]);
      rx.peerRate = pcf_rate_e'(MOD_TAB[rx.ind][2:0]);
      rdChk(OFS_RXSTAT, rx);
      chkWord({31'h0, peerSiso}, {31'h0, rx.siso});
   endtask : rxSend

   task automatic final_report();
      $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end

   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdChk(OFS_TXCFG, 32'h0040_0000);
      wr(8'h40, 32'hffff_ffff);
      rdChk(8'h40, 32'h0);
      wr(OFS_TXSTAT, 32'hffff_ffff);
      rdChk(OFS_TXSTAT, 32'h0);
      rdChk(OFS_RXIN, 32'h0);
      for (int i = 0; i < 16; i++)
         rxSend(1'b1, 5'h7, 5'h3, i[1:0], i[3:2], 4'(15 - i), i[3:0]);
      rxSend(1'b1, 5'h2, 5'h5, 2'h1, 2'h3, 4'h8, 4'h5);
      rxSend(1'b1, 5'h1f, 5'h0, 2'h2, 2'h1, 4'hc, 4'h9);
      rxSend(1'b1, 5'h4, 5'h4, 2'h0, 2'h3, 4'h3, 4'ha);
      rxSend(1'b0, 5'h9, 5'h1, 2'h1, 2'h0, 4'h2, 4'h2);
      wr(OFS_CTRL, 32'h4);
      for (int i = 0; i < 11; i++)
      begin
         wr(OFS_TXCFG, cfg(4'h1, 2'h0, 4'h0, 4'(i)));
         e = (i < 3) ? 4'(i) : 4'h3;
         chkWord({28'h0, txFields.ind}, {28'h0, e});
      end
      wr(OFS_CTRL, 32'h0);
      indiv <= 1'b1;
      chkWord({28'h0, txFields.ind}, 32'h0);
      rxSend(1'b1, 5'h7, 5'h3, 2'h0, 2'h0, 4'h6, 4'h0);
      for (int i = 0; i < 11; i++)
      begin
         wr(OFS_TXCFG, cfg(4'h1, 2'h0, 4'h0, 4'(i)));
         e = (i < 6) ? 4'(i) : 4'h6;
         e = (e == 4'h4) ? 4'h3 : e;
         chkWord({28'h0, txFields.ind}, {28'h0, e});
      end
      rxSend(1'b1, 5'h7, 5'h3, 2'h0, 2'h0, 4'ha, 4'h0);
      wr(OFS_TXCFG, cfg(4'h1, 2'h1, 4'h9, 4'ha));
      chkWord({19'h0, txFields[12:0]}, 32'h109a);
      wr(OFS_TXCFG, cfg(4'hf, 2'h2, 4'h4, 4'ha));
      chkWord({20'h0, txFields[11:0]}, 32'h29a);
      wr(OFS_CTRL, 32'h3);
      wr(OFS_TXCFG, cfg(4'hf, 2'h1, 4'h5, 4'h2));
      chkWord({20'h0, txFields[11:0]}, 32'h29a);
      wr(OFS_CTRL, 32'h0);
      chkWord({20'h0, txFields[11:0]}, 32'h152);
      wr(OFS_GCFG, 32'h0001_0000);
      for (int k = 0; k < 8; k++)
      begin
         gr = u_pcf_peer_model.grantWord(k[1:0], k[2:0], k[1:0], k[0], 5'(k * 3), k[0], k[2]);
         wr(OFS_GRX, {17'h0, gr});
         if (k[1:0] != 2'h0)
            {s1, s2} = k[1:0];
         e = k[2] ? ACC_DB[k[1:0]] : ABS_DB[k[1:0]];
         rdChk(OFS_GSTAT, {10'h0, s2, s1, ~k[0], e, gr});
      end
      gr = u_pcf_peer_model.grantWord(2'h3, 3'h5, 2'h2, 1'b0, 5'h11, 1'b1, 1'b0);
      wr(OFS_GCFG, {15'h0, 2'h3, gr});
      rdChk(OFS_GTX, {17'h0, gr | 15'h0080});
      wr(OFS_GCFG, {15'h0, 2'h3, gr});
      rdChk(OFS_GTX, {17'h0, gr});
      wr(OFS_GCFG, {15'h0, 2'h2, gr});
      chkWord({17'h0, txGrant}, {17'h0, gr});
      wr(OFS_GCFG, {15'h0, 2'h1, gr});
      chkWord({17'h0, txGrant}, {17'h0, (gr & 15'h1fff) | 15'h0080});
      chkWord({24'h0, violations}, 32'h0);
      final_report();
   end
endmodule : pcf_codec_bench
`default_nettype wire
